//--- hdl/pulse_timer_unit.sv
// Three-channel timer with status flags, request lines and DMA activation.
// Assumes an AXI4-Lite master on i_clk and synchronous tick and capture inputs.
`timescale 1ns/1ps
`include "pulse_timer_defs.svh"

// Operation
// RULE1: Each source has its own flag and enable: match, overflow, underflow.
// RULE2: A set flag raises its request only when its enable bit is one.
// RULE3: A request stays up until its flag returns to zero.
// RULE4: Fixed priority: A, B, C, D, overflow, underflow; channel 0 first.
// RULE5: Every source has its own request line.
// RULE6: Capture or compare on a general register sets its match flag.
// RULE7: Eight match sources: four on channel 0, two on channels 1, 2.
// RULE8: Overflow sets the channel's overflow flag on all three channels.
// RULE9: Underflow sets the underflow flag, only on channels 1 and 2.
// RULE10: Only the four channel 0 match sources may request DMA.
// RULE11: Compare match fires in the last state where counter equals register.
// RULE12: On compare match the programmed output level drives the pin.
// RULE13: No second match until the next counter input clock.
// RULE14: Selected clear source reloads the counter with zero.
// RULE15: Down-count wrapping zero to all ones sets the underflow flag.
// RULE16: Software clears a flag by reading it as one, then writing zero.
// RULE17: A DMA transfer clears its activating flag without CPU write.
// RULE18: CPU clear acts at write end; request drops the next clock.
// RULE19: Up-count wrapping all ones to zero sets overflow the same clock.
module pulse_timer_unit
  import pulse_timer_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [7:0] i_awaddr,
  input wire logic i_wvalid,
  output logic o_wready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  output logic o_bvalid,
  input wire logic i_bready,
  output logic [1:0] o_bresp,
  input wire logic i_arvalid,
  output logic o_arready,
  input wire logic [7:0] i_araddr,
  output logic o_rvalid,
  input wire logic i_rready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  input wire logic [2:0] i_count_tick,
  input wire logic [7:0] i_capture_pin,
  input wire logic [3:0] i_dma_done,
  output logic [7:0] o_compare_output_pin,
  output logic [7:0] o_match_irq,
  output logic [2:0] o_overflow_irq,
  output logic [1:0] o_underflow_irq,
  output logic [3:0] o_dma_req,
  output logic o_irq_pending,
  output logic [3:0] o_irq_source
);

  function automatic logic reg_ok(input logic [1:0] ch, input logic [3:0] r);
    if (ch == 2'h0) begin
      reg_ok = (r <= `REG_LAST_CH0);
    end else if (ch < `NUM_CH) begin
      reg_ok = (r <= `REG_LAST_CH12);
    end else begin
      reg_ok = 1'b0;
    end
  endfunction : reg_ok

  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [15:0] d,
                                          input logic [1:0] s);
    merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction : merge16

  function automatic logic [3:0] first_set(input logic [12:0] p);
    first_set = 4'h0;
    for (int i = 12; i >= 0; i--) begin
      if (p[i]) begin
        first_set = 4'(i);
      end
    end
  endfunction : first_set

  bus_state_t wr_state;
  bus_state_t rd_state;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;

  chan_cfg_t cfg [3];
  logic [15:0] ioctl [3];
  logic [5:0] ien [3];
  logic [15:0] cnt [3];
  logic [3:0][15:0] gr [3];
  logic [5:0] flags [3];
  logic [5:0] irq [3];
  logic [3:0] pin [3];

  wire [1:0] wr_ch = aw_addr[7:6];
  wire [3:0] wr_reg = aw_addr[5:2];
  wire wr_ok = reg_ok(wr_ch, wr_reg);
  wire wr_fire = (wr_state == BUS_IDLE) && !o_awready && !o_wready;
  wire [1:0] gidx = 2'(wr_reg - `REG_GR_A);
  wire [1:0] rd_ch = i_araddr[7:6];
  wire [3:0] rd_reg = i_araddr[5:2];
  wire rd_ok = reg_ok(rd_ch, rd_reg);
  wire rd_fire = i_arvalid && o_arready;

  // Write channel: address and data are held until both have arrived.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      wr_state <= BUS_IDLE;
      o_awready <= 1'b1;
      o_wready <= 1'b1;
      o_bvalid <= 1'b0;
      o_bresp <= `RESP_OKAY;
      aw_addr <= 8'h00;
      w_data <= 32'h0;
      w_strb <= 4'h0;
    end else begin
      if (i_awvalid && o_awready) begin
        o_awready <= 1'b0;
        aw_addr <= i_awaddr;
      end
      if (i_wvalid && o_wready) begin
        o_wready <= 1'b0;
        w_data <= i_wdata;
        w_strb <= i_wstrb;
      end
      case (wr_state)
        BUS_IDLE: begin
          if (wr_fire) begin
            wr_state <= BUS_ANSWER;
            o_bvalid <= 1'b1;
            o_bresp <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
          end
        end
        default: begin
          if (i_bready) begin
            wr_state <= BUS_IDLE;
            o_bvalid <= 1'b0;
            o_awready <= 1'b1;
            o_wready <= 1'b1;
          end
        end
      endcase
    end
  end

  logic [31:0] rd_word;

  always_comb begin
    rd_word = 32'h0;
    if (!rd_ok) begin
      rd_word = 32'h0;
    end else if (rd_reg == `REG_CTRL) begin
      rd_word = {28'h0, cfg[rd_ch]};
    end else if (rd_reg == `REG_IOCTL) begin
      rd_word = {16'h0, ioctl[rd_ch]};
    end else if (rd_reg == `REG_IEN) begin
      rd_word = {26'h0, ien[rd_ch]};
    end else if (rd_reg == `REG_STATUS) begin
      rd_word = {26'h0, flags[rd_ch]};
    end else if (rd_reg == `REG_COUNT) begin
      rd_word = {16'h0, cnt[rd_ch]};
    end else begin
      rd_word = {16'h0, gr[rd_ch][2'(rd_reg - `REG_GR_A)]};
    end
  end

  // Read channel: one word answered the cycle after the address is taken.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      rd_state <= BUS_IDLE;
      o_arready <= 1'b1;
      o_rvalid <= 1'b0;
      o_rdata <= 32'h0;
      o_rresp <= `RESP_OKAY;
    end else begin
      case (rd_state)
        BUS_IDLE: begin
          if (rd_fire) begin
            rd_state <= BUS_ANSWER;
            o_arready <= 1'b0;
            o_rvalid <= 1'b1;
            o_rdata <= rd_word;
            o_rresp <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
          end
        end
        default: begin
          if (i_rready) begin
            rd_state <= BUS_IDLE;
            o_rvalid <= 1'b0;
            o_arready <= 1'b1;
          end
        end
      endcase
    end
  end

  genvar c;
  for (c = 0; c < 3; c++) begin : g_ch
    localparam int NM = (c == 0) ? 4 : 2;
    wire sel_w = wr_fire && wr_ok && (wr_ch == 2'(c));
    wire [15:0] wd = merge16((wr_reg == `REG_COUNT) ? cnt[c] : gr[c][gidx],
                             w_data[15:0], w_strb[1:0]);
    wire [3:0] gr_we = (sel_w && wr_reg >= `REG_GR_A) ? (4'h1 << gidx) : 4'h0;
    wire [3:0] cap_in;
    wire [3:0] dma_clr;
    chan_event_t ev;

    if (c == 0) begin : g_full
      assign cap_in = i_capture_pin[3:0];
      assign dma_clr = i_dma_done; // RULE17
    end else begin : g_half
      assign cap_in = {2'b00, i_capture_pin[2*c+2 +: 2]};
      assign dma_clr = 4'h0; // RULE10
    end

    always_ff @(posedge i_clk) begin
      if (i_rst) begin
        cfg[c] <= chan_cfg_t'(4'h0);
        ioctl[c] <= 16'h0;
        ien[c] <= 6'h00;
      end else begin
        if (sel_w && wr_reg == `REG_CTRL && w_strb[0]) begin
          cfg[c] <= chan_cfg_t'(w_data[3:0]);
        end
        if (sel_w && wr_reg == `REG_IOCTL) begin
          ioctl[c] <= merge16(ioctl[c], w_data[15:0], w_strb[1:0]);
        end
        if (sel_w && wr_reg == `REG_IEN && w_strb[0]) begin
          ien[c] <= w_data[5:0];
        end
      end
    end

    timer_channel #(
      .NUM_MATCH(NM),
      .HAS_UNDERFLOW(c != 0) // RULE9
    ) u_chan (
      .i_clk(i_clk),
      .i_rst(i_rst),
      .i_cfg(cfg[c]),
      .i_io(ioctl[c]),
      .i_tick(i_count_tick[c]),
      .i_capture(cap_in),
      .i_cnt_we(sel_w && wr_reg == `REG_COUNT),
      .i_gr_we(gr_we),
      .i_wdata(wd),
      .o_count(cnt[c]),
      .o_gr(gr[c]),
      .o_events(ev),
      .o_pin(pin[c])
    );

    timer_flags u_flags (
      .i_clk(i_clk),
      .i_rst(i_rst),
      .i_events(ev),
      .i_enable(ien[c]),
      .i_read(rd_fire && rd_ok && rd_ch == 2'(c) && rd_reg == `REG_STATUS), // RULE16
      .i_write(sel_w && wr_reg == `REG_STATUS && w_strb[0]),
      .i_wdata(w_data[5:0]),
      .i_dma_clear(dma_clr),
      .o_flags(flags[c]),
      .o_irq(irq[c])
    );
  end

  // Separate lines per source; index 0 is the highest priority.
  assign o_match_irq = {irq[2][3:2], irq[1][3:2], irq[0][5:2]}; // RULE5 RULE7
  assign o_overflow_irq = {irq[2][`FLAG_OVF], irq[1][`FLAG_OVF], irq[0][`FLAG_OVF]}; // RULE8
  assign o_underflow_irq = {irq[2][`FLAG_UNF], irq[1][`FLAG_UNF]}; // RULE9
  assign o_dma_req = irq[0][5:2]; // RULE10
  assign o_compare_output_pin = {pin[2][1:0], pin[1][1:0], pin[0]};

  wire [12:0] pend = {irq[2][0], irq[2][1], irq[2][3], irq[2][2],
                      irq[1][0], irq[1][1], irq[1][3], irq[1][2],
                      irq[0][1], irq[0][5], irq[0][4], irq[0][3], irq[0][2]};

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_irq_pending <= 1'b0;
      o_irq_source <= 4'h0;
    end else begin
      o_irq_pending <= |pend;
      o_irq_source <= first_set(pend); // RULE4
    end
  end

endmodule : pulse_timer_unit

//--- hdl/timer_channel.sv
// One timer channel: counter, four general registers, match, capture and pins.
// Assumes i_tick and i_capture are synchronous to i_clk.
`timescale 1ns/1ps
`include "pulse_timer_defs.svh"

module timer_channel
  import pulse_timer_pkg::*;
#(
  parameter int NUM_MATCH = 4,
  parameter bit HAS_UNDERFLOW = 1'b1
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire chan_cfg_t i_cfg,
  input wire logic [15:0] i_io,
  input wire logic i_tick,
  input wire logic [3:0] i_capture,
  input wire logic i_cnt_we,
  input wire logic [3:0] i_gr_we,
  input wire logic [15:0] i_wdata,
  output logic [15:0] o_count,
  output logic [3:0][15:0] o_gr,
  output chan_event_t o_events,
  output logic [3:0] o_pin
);

  localparam logic [3:0] PRESENT = (NUM_MATCH == 4) ? 4'hf : 4'h3;

  function automatic logic clear_hit(input logic [3:0] h, input logic [2:0] s);
    case (s)
      3'h1: clear_hit = h[0];
      3'h2: clear_hit = h[1];
      3'h3: clear_hit = h[2];
      3'h4: clear_hit = h[3];
      default: clear_hit = 1'b0;
    endcase
  endfunction : clear_hit

  function automatic logic next_pin(input logic cur, input logic [1:0] m);
    case (m)
      `OUT_LOW: next_pin = 1'b0;
      `OUT_HIGH: next_pin = 1'b1;
      `OUT_TOGGLE: next_pin = ~cur;
      default: next_pin = cur;
    endcase
  endfunction : next_pin

  logic [3:0] capture_prev;
  logic [3:0] cmp_hit;
  logic [3:0] cap_hit;

  always_comb begin
    for (int i = 0; i < 4; i++) begin
      cmp_hit[i] = PRESENT[i] & ~i_io[4*i+`IO_CAPTURE_BIT] & i_tick & (o_count == o_gr[i]); // RULE11 RULE13
      cap_hit[i] = PRESENT[i] & i_io[4*i+`IO_CAPTURE_BIT] & i_capture[i] & ~capture_prev[i];
    end
  end

  wire [3:0] hit = cmp_hit | cap_hit; // RULE6
  wire count_down = HAS_UNDERFLOW & i_cfg.count_down;
  wire clear = clear_hit(hit, i_cfg.clear_sel);
  wire wrap_up = i_tick & ~count_down & (o_count == `CNT_MAX);
  wire wrap_down = i_tick & count_down & (o_count == `CNT_ZERO);
  wire no_flag = clear | i_cnt_we;
  wire [15:0] next_count = i_cnt_we ? i_wdata :
                           clear ? `CNT_ZERO : // RULE14
                           !i_tick ? o_count :
                           count_down ? o_count - 16'h0001 : o_count + 16'h0001;

  assign o_events.match = hit;
  assign o_events.overflow = wrap_up & ~no_flag; // RULE19
  assign o_events.underflow = wrap_down & ~no_flag; // RULE15

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_count <= `CNT_ZERO;
      capture_prev <= 4'h0;
    end else begin
      o_count <= next_count;
      capture_prev <= i_capture;
    end
  end

  always_ff @(posedge i_clk) begin
    for (int i = 0; i < 4; i++) begin
      if (i_rst) begin
        o_gr[i] <= `GR_RESET;
        o_pin[i] <= 1'b0;
      end else begin
        if (cap_hit[i]) begin
          o_gr[i] <= o_count;
        end else if (i_gr_we[i]) begin
          o_gr[i] <= i_wdata;
        end
        if (cmp_hit[i]) begin
          o_pin[i] <= next_pin(o_pin[i], i_io[4*i +: 2]); // RULE12
        end
      end
    end
  end

endmodule : timer_channel

//--- hdl/timer_flags.sv
// Status flags, clear sequence and registered request lines of one channel.
// Assumes one-cycle read and write strobes from the register slave.
`timescale 1ns/1ps
`include "pulse_timer_defs.svh"

module timer_flags
  import pulse_timer_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire chan_event_t i_events,
  input wire logic [5:0] i_enable,
  input wire logic i_read,
  input wire logic i_write,
  input wire logic [5:0] i_wdata,
  input wire logic [3:0] i_dma_clear,
  output logic [5:0] o_flags,
  output logic [5:0] o_irq
);

  logic [5:0] armed;

  wire [5:0] cpu_clear = i_write ? (armed & ~i_wdata) : 6'h00; // RULE16
  wire [5:0] dma_clear = {i_dma_clear, 2'b00}; // RULE17
  wire [5:0] next_flags = i_events | (o_flags & ~cpu_clear & ~dma_clear); // RULE1
  wire [5:0] next_armed = i_read ? o_flags : (i_write ? 6'h00 : armed);

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_flags <= 6'h00;
      armed <= 6'h00;
      o_irq <= 6'h00;
    end else begin
      o_flags <= next_flags; // RULE18
      armed <= next_armed;
      o_irq <= o_flags & i_enable; // RULE2 RULE3
    end
  end

endmodule : timer_flags

//--- shared/pulse_timer_defs.svh
// Offsets, field positions, reset values and limits of the three-channel timer.
// Included by the timer design files; holds definitions only.
`ifndef PULSE_TIMER_DEFS_SVH
`define PULSE_TIMER_DEFS_SVH

// Register index inside a channel, taken from address bits 5:2.
`define REG_CTRL 4'h0
`define REG_IOCTL 4'h1
`define REG_IEN 4'h2
`define REG_STATUS 4'h3
`define REG_COUNT 4'h4
`define REG_GR_A 4'h5
`define REG_LAST_CH0 4'h8
`define REG_LAST_CH12 4'h6
`define NUM_CH 2'h3

// Status and enable field positions.
`define FLAG_UNF 0
`define FLAG_OVF 1
`define FLAG_MATCH_LSB 2

// Per general register, four bits of the I/O control register.
`define IO_CAPTURE_BIT 3
`define OUT_HOLD 2'h0
`define OUT_LOW 2'h1
`define OUT_HIGH 2'h2
`define OUT_TOGGLE 2'h3

`define CNT_ZERO 16'h0000
`define CNT_MAX 16'hffff
`define GR_RESET 16'hffff

`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

//--- shared/pulse_timer_pkg.sv
// Types shared by the timer design files.
// Used with pulse_timer_defs.svh for the numeric constants.
package pulse_timer_pkg;

  typedef struct packed {
    logic count_down;
    logic [2:0] clear_sel;
  } chan_cfg_t;

  typedef struct packed {
    logic [3:0] match;
    logic overflow;
    logic underflow;
  } chan_event_t;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'b00,
    BUS_ANSWER = 2'b01
  } bus_state_t;

endpackage : pulse_timer_pkg

//--- testbench/dma_ctrl_model.sv
// DMA controller model: answers each activation line with a one-cycle done pulse.
// Assumes level activation lines on i_clk; i_slow picks a long answer time per line.
`timescale 1ns/1ps
module dma_ctrl_model (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_on,
  input wire logic [3:0] i_slow,
  input wire logic [3:0] i_req,
  output logic [3:0] o_done
);
  int cnt [4];
  logic [3:0] busy;
  always_ff @(posedge i_clk) begin
    for (int i = 0; i < 4; i++) begin
      o_done[i] <= 1'b0;
      if (i_rst) begin
        busy[i] <= 1'b0;
        cnt[i] <= 0;
      end else if (!busy[i] && i_on && i_req[i]) begin
        busy[i] <= 1'b1;
        cnt[i] <= i_slow[i] ? 6 : 1;
      end else if (busy[i] && cnt[i] == 1) begin
        o_done[i] <= 1'b1;
        cnt[i] <= 0;
      end else if (busy[i] && cnt[i] > 1) begin
        cnt[i] <= cnt[i] - 1;
      end else if (busy[i] && !i_req[i]) begin
        busy[i] <= 1'b0;
      end
    end
  end
endmodule : dma_ctrl_model

//--- testbench/tb.sv
// Self-checking bench of the timer unit: flags, request lines, priority and DMA clearing.
// Assumes the checker and the DMA model are compiled before it.
`timescale 1ns/1ps
`include "pulse_timer_defs.svh"
module tb;
  logic i_clk = 1'b0, i_rst = 1'b1, awv = 1'b0, wv = 1'b0, bready = 1'b0;
  logic arv = 1'b0, rready = 1'b0, dma_on = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00, cap = 8'h00, pins, mirq;
  logic [31:0] wdata = 32'h0, seed = 32'hab09, rdata, d;
  logic [2:0] tick = 3'h0, ovf;
  logic [3:0] slow = 4'h0, dreq, done, src;
  logic awready, wready, bvalid, arready, rvalid, pend;
  logic [1:0] bresp, rresp, unf, resp;
  int failures = 0, compares = 0, c, r, v;
  int mflag [3] = '{0, 0, 0};
  int men [3] = '{0, 0, 0};
  wire logic [12:0] got = {unf[1], ovf[2], mirq[7:6], unf[0], ovf[1], mirq[5:4], ovf[0], mirq[3:0]};
  pulse_timer_unit dut_u (.i_clk(i_clk), .i_rst(i_rst), .i_awvalid(awv), .o_awready(awready),
    .i_awaddr(awaddr), .i_wvalid(wv), .o_wready(wready), .i_wdata(wdata), .i_wstrb(4'hf),
    .o_bvalid(bvalid), .i_bready(bready), .o_bresp(bresp), .i_arvalid(arv), .o_arready(arready),
    .i_araddr(araddr), .o_rvalid(rvalid), .i_rready(rready), .o_rdata(rdata), .o_rresp(rresp),
    .i_count_tick(tick), .i_capture_pin(cap), .i_dma_done(done), .o_compare_output_pin(pins),
    .o_match_irq(mirq), .o_overflow_irq(ovf), .o_underflow_irq(unf), .o_dma_req(dreq),
    .o_irq_pending(pend), .o_irq_source(src));
  dma_ctrl_model pal_u (.i_clk(i_clk), .i_rst(i_rst), .i_on(dma_on), .i_slow(slow),
    .i_req(dreq), .o_done(done));
  initial begin
    forever #50 i_clk = ~i_clk;
  end
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd
  function automatic logic [7:0] ad(input int ch, input logic [3:0] rg);
    return {ch[1:0], rg, 2'b00};
  endfunction : ad
  task automatic axw(input logic [7:0] a, input logic [31:0] x);
    logic ta, tw, tk;
    @(posedge i_clk);
    awv <= 1'b1;
    wv <= 1'b1;
    awaddr <= a;
    wdata <= x;
    bready <= 1'b1;
    do begin
      @(negedge i_clk);
      ta = awv && awready;
      tw = wv && wready;
      tk = bvalid;
      resp = bresp;
      @(posedge i_clk);
      if (ta) awv <= 1'b0;
      if (tw) wv <= 1'b0;
    end while (!tk);
    bready <= 1'b0;
  endtask : axw
  task automatic axr(input logic [7:0] a);
    logic ta, tk;
    @(posedge i_clk);
    arv <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    do begin
      @(negedge i_clk);
      ta = arv && arready;
      tk = rvalid;
      d = rdata;
      resp = rresp;
      @(posedge i_clk);
      if (ta) arv <= 1'b0;
    end while (!tk);
    rready <= 1'b0;
  endtask : axr
  task automatic pulse(input int ch, input int n);
    repeat (n) begin
      @(posedge i_clk);
      tick[ch] <= 1'b1;
      @(posedge i_clk);
      tick[ch] <= 1'b0;
    end
    repeat (3) @(posedge i_clk);
  endtask : pulse
  task automatic check_all();
    logic [5:0] m0, m1, m2;
    for (int k = 0; k < 3; k++) begin
      axr(ad(k, `REG_STATUS));
      chk("status", 32'(mflag[k]), d);
    end
    m0 = 6'(mflag[0] & men[0]);
    m1 = 6'(mflag[1] & men[1]);
    m2 = 6'(mflag[2] & men[2]);
    chk("lines", {m2[0], m2[1], m2[3:2], m1[0], m1[1], m1[3:2], m0[1], m0[5:2]}, got);
    chk("dma", m0[5:2], dreq);
    chk("pending", (m0 | m1 | m2) != 6'h0, pend);
  endtask : check_all
  task automatic clr(input int ch, input int bits);
    axr(ad(ch, `REG_STATUS));
    axw(ad(ch, `REG_STATUS), 32'(mflag[ch] & ~bits));
    mflag[ch] = mflag[ch] & ~bits;
  endtask : clr
  task automatic results();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : results
  initial begin
    repeat (20000) @(posedge i_clk);
    failures++;
    results();
  end
  initial begin
    repeat (12) @(posedge i_clk);
    i_rst <= 1'b0;
    axr(ad(1, `REG_GR_A));
    chk("gr reset", `GR_RESET, d);
    check_all();
    axr(8'h5c);
    chk("unmapped", {30'h0, `RESP_SLVERR}, {d[29:0], resp});
    axw(8'h5c, 32'h1);
    chk("bresp", {30'h0, `RESP_SLVERR}, {30'h0, resp});
    for (int k = 0; k < 8; k++) begin
      c = k < 4 ? 0 : (k < 6 ? 1 : 2);
      r = k < 4 ? k : k % 2;
      v = int'(rnd() % 8) + 1;
      men[c] = int'(rnd() % 2) << (2 + r);
      axw(ad(c, `REG_COUNT), 32'h0);
      axw(ad(c, 4'(`REG_GR_A + r)), 32'(v));
      axw(ad(c, `REG_IEN), 32'(men[c]));
      axw(ad(c, `REG_IOCTL), 32'(2 << (4 * r)));
      pulse(c, v);
      check_all();
      pulse(c, 1);
      mflag[c] = 1 << (2 + r);
      check_all();
      chk("pin", 32'h1, {31'h0, pins[k]});
      axw(ad(c, `REG_STATUS), 32'(mflag[c]));
      axw(ad(c, `REG_STATUS), 32'h0);
      check_all();
      clr(c, mflag[c]);
      check_all();
      axw(ad(c, 4'(`REG_GR_A + r)), 32'h8000);
    end
    for (c = 0; c < 3; c++) begin
      men[c] = 2;
      axw(ad(c, `REG_IEN), 32'h2);
      axw(ad(c, `REG_COUNT), `CNT_MAX);
      pulse(c, 1);
      mflag[c] = 2;
    end
    check_all();
    chk("source", 32'h4, {28'h0, src});
    clr(0, 2);
    check_all();
    chk("source", 32'h7, {28'h0, src});
    for (c = 1; c < 3; c++) begin
      men[c] = 3;
      axw(ad(c, `REG_IEN), 32'h3);
      axw(ad(c, `REG_CTRL), 32'h8);
      axw(ad(c, `REG_COUNT), `CNT_ZERO);
      pulse(c, 1);
      mflag[c] = 3;
      axr(ad(c, `REG_COUNT));
      chk("wrap", `CNT_MAX, d);
    end
    check_all();
    clr(1, 3);
    clr(2, 3);
    axw(ad(1, `REG_CTRL), 32'h1);
    axw(ad(1, `REG_GR_A), 32'h3);
    axw(ad(1, `REG_COUNT), 32'h0);
    pulse(1, 4);
    axr(ad(1, `REG_COUNT));
    chk("cleared", 32'h0, d);
    mflag[1] = 4;
    check_all();
    clr(1, 4);
    axw(ad(2, `REG_IOCTL), 32'h8);
    axw(ad(2, `REG_COUNT), 32'h42);
    @(posedge i_clk);
    cap[6] <= 1'b1;
    repeat (3) @(posedge i_clk);
    axr(ad(2, `REG_GR_A));
    chk("capture", 32'h42, d);
    mflag[2] = 4;
    check_all();
    clr(2, 4);
    for (r = 0; r < 4; r++) axw(ad(0, 4'(`REG_GR_A + r)), 32'h2);
    men[0] = 'h3c;
    axw(ad(0, `REG_IEN), 32'h3c);
    for (int n = 0; n < 2; n++) begin
      @(posedge i_clk);
      slow <= n == 0 ? 4'hf : 4'(rnd());
      dma_on <= 1'b1;
      axw(ad(0, `REG_COUNT), 32'h0);
      pulse(0, 3);
      @(negedge i_clk);
      if (n == 0) chk("dma up", 32'hf, {28'h0, dreq});
      repeat (20) @(posedge i_clk);
      check_all();
    end
    results();
  end
endmodule : tb

//--- testbench/timer_irq_sva.sv
// Checker of request lines, priority index and DMA activation of the timer unit.
// Assumes it is bound to pulse_timer_unit and sees only that module's ports.
`timescale 1ns/1ps
module timer_irq_sva (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic o_bvalid,
  input wire logic [2:0] i_count_tick,
  input wire logic [7:0] i_capture_pin,
  input wire logic [3:0] i_dma_done,
  input wire logic [7:0] o_compare_output_pin,
  input wire logic [7:0] o_match_irq,
  input wire logic [2:0] o_overflow_irq,
  input wire logic [1:0] o_underflow_irq,
  input wire logic [3:0] o_dma_req,
  input wire logic o_irq_pending,
  input wire logic [3:0] o_irq_source
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  // All request lines, lowest bit has the highest priority.
  wire logic [12:0] lines = {o_underflow_irq[1], o_overflow_irq[2], o_match_irq[7:6],
    o_underflow_irq[0], o_overflow_irq[1], o_match_irq[5:4], o_overflow_irq[0], o_match_irq[3:0]};
  function automatic logic [3:0] first(input logic [12:0] v);
    first = 4'h0;
    for (int i = 12; i >= 0; i--) if (v[i]) first = 4'(i);
  endfunction : first
  property p_mirror; o_dma_req == o_match_irq[3:0]; endproperty
  a_mirror: assert property (p_mirror) else $error("dma request differs from match line");
  property p_pending; o_irq_pending == ($past(lines) != 13'h0); endproperty
  a_pending: assert property (p_pending) else $error("pending flag wrong");
  property p_order; $past(lines) != 13'h0 |-> o_irq_source == first($past(lines)); endproperty
  a_order: assert property (p_order) else $error("priority index wrong");
  property p_drop; ($past(lines) & ~lines) != 13'h0 |-> $past(i_rst) || $past(o_bvalid)
    || $past(o_bvalid, 2) || $past(i_dma_done, 2) != 4'h0 || $past(i_dma_done, 3) != 4'h0;
  endproperty
  a_drop: assert property (p_drop) else $error("request dropped without clear");
  property p_dma_clear; i_dma_done[0] && o_dma_req[0] && !i_count_tick[0] && !i_capture_pin[0]
    |-> ##2 (!o_dma_req[0] || $past(i_count_tick[0])); endproperty
  a_dma_clear: assert property (p_dma_clear) else $error("dma done did not clear");
  property p_pin; $changed(o_compare_output_pin[0])
    |-> $past(i_count_tick[0]) || $past(i_count_tick[0], 2); endproperty
  a_pin: assert property (p_pin) else $error("output pin moved without match");
  property p_ovf; $rose(o_overflow_irq[0])
    |-> $past(o_bvalid) || $past(o_bvalid, 2) || $past(i_count_tick[0], 2); endproperty
  a_ovf: assert property (p_ovf) else $error("overflow line rose without cause");
  property p_unf; $rose(o_underflow_irq[0])
    |-> $past(o_bvalid) || $past(o_bvalid, 2) || $past(i_count_tick[1], 2); endproperty
  a_unf: assert property (p_unf) else $error("underflow line rose without cause");
  c_dma: cover property (o_dma_req == 4'hf);
  c_ovf: cover property (o_overflow_irq == 3'h7);
  c_unf: cover property (o_underflow_irq == 2'h3);
endmodule : timer_irq_sva
bind pulse_timer_unit timer_irq_sva chk_u (.i_clk(i_clk), .i_rst(i_rst), .o_bvalid(o_bvalid),
  .i_count_tick(i_count_tick), .i_capture_pin(i_capture_pin), .i_dma_done(i_dma_done),
  .o_compare_output_pin(o_compare_output_pin), .o_match_irq(o_match_irq),
  .o_overflow_irq(o_overflow_irq), .o_underflow_irq(o_underflow_irq), .o_dma_req(o_dma_req),
  .o_irq_pending(o_irq_pending), .o_irq_source(o_irq_source));
